// ===== verilog/bstp_top.sv
// boundary-scan test access port with revision dependent chain
`default_nettype none
module bstp_top (
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst,
    // test pins and revision strap, asynchronous to mclk
    input  wire bstp_pkg::bstp_pins_s              pins,
    // core side
    input  wire logic [bstp_pkg::BSR_LEN-1:0]      pin_state,
    input  wire logic [bstp_pkg::GRP_N-1:0]        core_oe,
    // pin side
    output logic                                   tdo,
    output logic                                   tdo_oe,
    output logic [bstp_pkg::GRP_N-1:0]             grp_oe,
    output logic [bstp_pkg::BSR_LEN-1:0]           bs_update,
    output logic                                   extest_on
);
    localparam int unsigned L = bstp_pkg::BSR_LEN;
    localparam int unsigned A = bstp_pkg::ADDED_CELL;

    // how the port behaves, seen from the core clock:
    // - tck, tms, tdi and the test reset are oversampled on mclk through two flops,
    //   so tck must stay high and low for at least four mclk periods
    // - a tck edge is acted on three mclk after it reaches the pin
    // - the test reset is level sampled, not truly asynchronous: it takes effect
    //   three mclk after the pin falls, which is ample for a board tester
    // - the chain shifts toward cell 0; on early silicon the added cell is left
    //   out of the shift path and simply keeps its captured value

    bstp_pkg::bstp_pins_s       s1_r, s2_r;
    logic                       tck_d_r;
    logic                       rev_r, rev_nxt;
    bstp_pkg::bstp_state_e      st_r, st_nxt;
    logic [bstp_pkg::IR_W-1:0]  ir_r, ir_nxt, irs_r, irs_nxt;
    logic [L-1:0]               bsr_r, bsr_nxt, upd_r, upd_nxt;
    logic                       byp_r, byp_nxt;
    logic                       tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
    logic [bstp_pkg::GRP_N-1:0] goe_r, goe_nxt;
    logic                       ext_r, ext_nxt;
    logic                       trst, rise, fall, sel_bsr;

    // two-flop synchroniser, then a third stage for tck edges
    always_ff @(posedge mclk) begin
        s1_r    <= pins;
        s2_r    <= s1_r;
        tck_d_r <= s2_r.tck;
    end

    assign rise    = s2_r.tck & ~tck_d_r;
    assign fall    = ~s2_r.tck & tck_d_r;
    assign trst    = rst | ~s2_r.trst_n;
    assign sel_bsr = (ir_r == bstp_pkg::IR_EXTEST) | (ir_r == bstp_pkg::IR_SAMPLE);

    // revision strap caught while reset is applied
    always_comb begin
        rev_nxt = rst ? s2_r.rev_later : rev_r;
    end

    // state machine steps only on tck rise and while test reset high
    always_comb begin
        st_nxt = st_r;
        if (trst) begin
            st_nxt = bstp_pkg::TLR;
        end else if (rise) begin
            case (st_r)
                bstp_pkg::TLR:    st_nxt = s2_r.tms ? bstp_pkg::TLR    : bstp_pkg::RTI;
                bstp_pkg::RTI:    st_nxt = s2_r.tms ? bstp_pkg::SEL_DR : bstp_pkg::RTI;
                bstp_pkg::SEL_DR: st_nxt = s2_r.tms ? bstp_pkg::SEL_IR : bstp_pkg::CAP_DR;
                bstp_pkg::CAP_DR: st_nxt = s2_r.tms ? bstp_pkg::EX1_DR : bstp_pkg::SH_DR;
                bstp_pkg::SH_DR:  st_nxt = s2_r.tms ? bstp_pkg::EX1_DR : bstp_pkg::SH_DR;
                bstp_pkg::EX1_DR: st_nxt = s2_r.tms ? bstp_pkg::UPD_DR : bstp_pkg::PAU_DR;
                bstp_pkg::PAU_DR: st_nxt = s2_r.tms ? bstp_pkg::EX2_DR : bstp_pkg::PAU_DR;
                bstp_pkg::EX2_DR: st_nxt = s2_r.tms ? bstp_pkg::UPD_DR : bstp_pkg::SH_DR;
                bstp_pkg::UPD_DR: st_nxt = s2_r.tms ? bstp_pkg::SEL_DR : bstp_pkg::RTI;
                bstp_pkg::SEL_IR: st_nxt = s2_r.tms ? bstp_pkg::TLR    : bstp_pkg::CAP_IR;
                bstp_pkg::CAP_IR: st_nxt = s2_r.tms ? bstp_pkg::EX1_IR : bstp_pkg::SH_IR;
                bstp_pkg::SH_IR:  st_nxt = s2_r.tms ? bstp_pkg::EX1_IR : bstp_pkg::SH_IR;
                bstp_pkg::EX1_IR: st_nxt = s2_r.tms ? bstp_pkg::UPD_IR : bstp_pkg::PAU_IR;
                bstp_pkg::PAU_IR: st_nxt = s2_r.tms ? bstp_pkg::EX2_IR : bstp_pkg::PAU_IR;
                bstp_pkg::EX2_IR: st_nxt = s2_r.tms ? bstp_pkg::UPD_IR : bstp_pkg::SH_IR;
                bstp_pkg::UPD_IR: st_nxt = s2_r.tms ? bstp_pkg::SEL_DR : bstp_pkg::RTI;
                default:          st_nxt = bstp_pkg::TLR;
            endcase
        end
    end

    // instruction register: shift stage and update latch
    always_comb begin
        ir_nxt  = ir_r;
        irs_nxt = irs_r;
        if (trst || (st_r == bstp_pkg::TLR)) begin
            ir_nxt  = bstp_pkg::IR_BYPASS;
            irs_nxt = bstp_pkg::IR_BYPASS;
        end else if (rise) begin
            case (st_r)
                bstp_pkg::CAP_IR: irs_nxt = bstp_pkg::IR_CAPTURE;
                bstp_pkg::SH_IR:  irs_nxt = {s2_r.tdi, irs_r[bstp_pkg::IR_W-1:1]};
                bstp_pkg::UPD_IR: ir_nxt  = irs_r;
                default:          irs_nxt = irs_r;
            endcase
        end
    end

    // boundary and bypass data registers
    always_comb begin
        bsr_nxt = bsr_r;
        upd_nxt = upd_r;
        byp_nxt = byp_r;
        if (trst) begin
            bsr_nxt = '0;
            upd_nxt = '0;
            byp_nxt = 1'b0;
        end else if (rise) begin
            case (st_r)
                bstp_pkg::CAP_DR: begin
                    byp_nxt = 1'b0;
                    if (sel_bsr) begin
                        bsr_nxt = pin_state;
                    end
                end
                bstp_pkg::SH_DR: begin
                    byp_nxt = s2_r.tdi;
                    if (sel_bsr) begin
                        bsr_nxt = {s2_r.tdi, bsr_r[L-1:1]};
                        if (!rev_r) begin
                            bsr_nxt[A-1] = bsr_r[A+1];  // early chain skips cell
                            bsr_nxt[A]   = bsr_r[A];    // added cell idle
                        end
                    end
                end
                bstp_pkg::UPD_DR: begin
                    if (sel_bsr) begin
                        upd_nxt = bsr_r;
                    end
                end
                default: byp_nxt = byp_r;
            endcase
        end
    end

    // test data out changes on tck fall while shifting
    always_comb begin
        tdo_nxt    = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        if (trst) begin
            tdo_nxt    = 1'b0;
            tdo_oe_nxt = 1'b0;
        end else if (fall) begin
            tdo_oe_nxt = (st_r == bstp_pkg::SH_DR) | (st_r == bstp_pkg::SH_IR);
            if (st_r == bstp_pkg::SH_IR) begin
                tdo_nxt = irs_r[0];
            end else if (st_r == bstp_pkg::SH_DR) begin
                tdo_nxt = sel_bsr ? bsr_r[0] : byp_r;
            end
        end
    end

    // group output enables: core owns them unless external test drives
    always_comb begin
        ext_nxt = ~trst & (ir_r == bstp_pkg::IR_EXTEST) & (st_r != bstp_pkg::TLR);
        for (int g = 0; g < bstp_pkg::GRP_N; g++) begin
            goe_nxt[g] = ext_nxt ? ~upd_r[bstp_pkg::GRP_CELL[g]] : core_oe[g];
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= bstp_pkg::TLR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // instruction registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ir_r  <= bstp_pkg::IR_BYPASS;
            irs_r <= bstp_pkg::IR_BYPASS;
        end else begin
            ir_r  <= ir_nxt;
            irs_r <= irs_nxt;
        end
    end

    // boundary, update and bypass registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            bsr_r <= '0;
            upd_r <= '0;
            byp_r <= 1'b0;
        end else begin
            bsr_r <= bsr_nxt;
            upd_r <= upd_nxt;
            byp_r <= byp_nxt;
        end
    end

    // test data out registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    // group enable and external test registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            goe_r <= bstp_pkg::GRP_OE_RST;
            ext_r <= 1'b0;
        end else begin
            goe_r <= goe_nxt;
            ext_r <= ext_nxt;
        end
    end

    // strap register, no reset: it is loaded while reset is applied
    always_ff @(posedge mclk) begin
        rev_r <= rev_nxt;
    end

    assign tdo       = tdo_r;
    assign tdo_oe    = tdo_oe_r;
    assign grp_oe    = goe_r;
    assign bs_update = upd_r;
    assign extest_on = ext_r;
endmodule
`default_nettype wire

// ===== verilog/bstp_pkg.sv
// package of constants and types for the boundary-scan test port
// How it works
// - test reset low holds test logic reset
// - state machine runs only while reset high
// - later silicon adds cell 87, renumbers rest
// - early revision skips cell 87 in chain
// - reset low: logic-reset state, bypass instruction
// - logic-reset state leaves normal function untouched
// - leave reset only by mode-select sequence
`default_nettype none
package bstp_pkg;
    localparam int unsigned BSR_LEN    = 143;    // cells 0..142, later numbering
    localparam int unsigned ADDED_CELL = 87;     // input cell present on later silicon
    localparam int unsigned GRP_N      = 4;
    localparam int unsigned IR_W       = 4;
    // group disable control cell positions, later numbering, index is group
    localparam int unsigned GRP_CELL [GRP_N] = '{141, 117, 110, 91};
    localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
    localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0]      GRP_OE_RST = 4'h0;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bstp_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
        logic rev_later;
    } bstp_pins_s;
endpackage
`default_nettype wire

// ===== sim/bstp_top_checker.sv
// assertions on the test port boundary
`default_nettype none
module bstp_top_checker (
    // watched ports
    input wire logic                         mclk,
    input wire logic                         rst,
    input wire bstp_pkg::bstp_pins_s         pins,
    input wire logic [bstp_pkg::BSR_LEN-1:0] pin_state,
    input wire logic [bstp_pkg::GRP_N-1:0]   core_oe,
    input wire logic                         tdo,
    input wire logic                         tdo_oe,
    input wire logic [bstp_pkg::GRP_N-1:0]   grp_oe,
    input wire logic [bstp_pkg::BSR_LEN-1:0] bs_update,
    input wire logic                         extest_on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // reset and test reset
    a_rst_clear: assert property ($fell(rst) |-> !tdo_oe && !extest_on && grp_oe == 4'h0)
        else $error("outputs not clear after reset");
    a_trst_idle: assert property (!pins.trst_n [*4] |-> !extest_on && !tdo_oe)
        else $error("test logic active under test reset");
    a_trst_clear: assert property (!pins.trst_n [*4] |-> !tdo && bs_update == '0)
        else $error("test data not cleared under test reset");
    a_oe_needs_trst: assert property ($rose(tdo_oe) |-> $past(pins.trst_n, 4))
        else $error("tdo driven without test reset high");
    a_ext_needs_trst: assert property ($rose(extest_on) |-> $past(pins.trst_n, 8))
        else $error("external test entered without test reset high");
    // enables pass through outside external test
    a_oe_follow: assert property (
        !extest_on && !$past(extest_on) && !$past(rst) |-> grp_oe == $past(core_oe))
        else $error("group enable does not follow core");
    // group control cells under external test
    a_grp0_gate: assert property (
        extest_on && $past(extest_on) && $past(bs_update[bstp_pkg::GRP_CELL[0]])
        |-> !grp_oe[0])
        else $error("group 0 not disabled");
    a_grp3_open: assert property (
        extest_on && $past(extest_on) && !$past(bs_update[bstp_pkg::GRP_CELL[3]])
        |-> grp_oe[3] == $past(core_oe[3]))
        else $error("group 3 wrongly disabled");
    // main scenarios
    c_extest: cover property ($rose(extest_on));
    c_shift: cover property ($rose(tdo_oe));
    c_gated: cover property (extest_on && grp_oe != core_oe);
endmodule
bind bstp_top bstp_top_checker i_bstp_top_checker (.mclk(mclk), .rst(rst), .pins(pins),
    .pin_state(pin_state), .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .grp_oe(grp_oe),
    .bs_update(bs_update), .extest_on(extest_on));
`default_nettype wire

// ===== sim/bstp_tester.sv
// tester model that drives the test pins
`default_nettype none
module bstp_tester (
    // clock and answer
    input  wire logic                mclk,
    input  wire logic                tdo,
    input  wire logic                tdo_oe,
    // test pins
    output var bstp_pkg::bstp_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // tck stands high, test reset low until a session
    initial pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    // one tck period: tms and tdi set at the fall, tdo taken before the rise
    task automatic tick(input logic ms, input logic di, output logic o);
        @(posedge mclk);
        #1 pins.tck = 1'b0;
        pins.tms = ms;
        pins.tdi = di;
        repeat (6) @(posedge mclk);
        o = tdo_oe ? tdo : 1'b1; // an undriven tdo floats high on its pull-up
        #1 pins.tck = 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    // test reset and strap change just after an edge
    task automatic set_pin(input logic trst_n, input logic rev);
        @(posedge mclk);
        #1 pins.trst_n = trst_n;
        pins.rev_later = rev;
    endtask
endmodule
`default_nettype wire

// ===== sim/test_boundary_scan_test_port.sv
// self-checking bench for the boundary-scan test port
`default_nettype none
module test_boundary_scan_test_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 mclk = 1'b0;
    logic                 rst = 1'b1;
    logic [142:0]         pin_state;
    logic [3:0]           core_oe = 4'ha;
    bstp_pkg::bstp_pins_s pins;
    logic                 tdo, tdo_oe, extest_on;
    logic [3:0]           grp_oe, cap;
    logic [142:0]         bs_update, got;
    int                   fail_count = 0;
    int                   compares = 0;
    // free running clock
    always #4 mclk = ~mclk;
    bstp_top i_bstp_top (.mclk(mclk), .rst(rst), .pins(pins), .pin_state(pin_state),
        .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .grp_oe(grp_oe), .bs_update(bs_update),
        .extest_on(extest_on));
    bstp_tester i_bstp_tester (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));
    // compare and count
    task automatic chk(input string what, input logic [142:0] exp, input logic [142:0] seen);
        compares++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    // tms walk with tdi low, first step in bit 0
    task automatic walk(input logic [7:0] t, input int n);
        logic o;
        for (int i = 0; i < n; i++) i_bstp_tester.tick(t[i], 1'b0, o);
    endtask
    // instruction load from idle back to idle
    task automatic ir_load(input logic [3:0] v);
        walk(8'h03, 4);
        for (int i = 0; i < 4; i++) i_bstp_tester.tick(i == 3, v[i], cap[i]);
        walk(8'h01, 2);
    endtask
    // capture, shift n cells, update, back to idle
    task automatic dr_shift(input int n, input logic [142:0] din);
        got = '0;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) i_bstp_tester.tick(i == n - 1, din[i], got[i]);
        walk(8'h01, 2);
    endtask
    // release test reset and reach idle
    task automatic session(input logic rev);
        i_bstp_tester.set_pin(1'b1, rev);
        repeat (4) @(posedge mclk);
        walk(8'h1f, 6);
    endtask
    // tck activity under test reset is ignored
    task automatic trst_low;
        walk(8'h1f, 6);
        ir_load(bstp_pkg::IR_EXTEST);
        chk("extest_on", 143'h0, 143'(extest_on));
        chk("tdo_oe", 143'h0, 143'(tdo_oe));
        chk("grp_oe", 143'ha, 143'(grp_oe));
    endtask
    // capture value and external test entry
    task automatic ir_extest;
        session(1'b1);
        ir_load(bstp_pkg::IR_EXTEST);
        chk("ir capture", 143'(bstp_pkg::IR_CAPTURE), 143'(cap));
        chk("extest_on", 143'h1, 143'(extest_on));
    endtask
    // later chain with added cell, group 0 control set
    task automatic chain_later;
        #1 core_oe = 4'hf;
        dr_shift(143, 143'h1 << 141);
        chk("chain later", pin_state, got);
        chk("bs_update", 143'h1 << 141, bs_update);
        chk("grp_oe", 143'he, 143'(grp_oe));
    endtask
    // early chain skips cell 87
    task automatic chain_early;
        logic [142:0] exp;
        exp = '0;
        for (int k = 0; k < 142; k++) exp[k] = pin_state[k < 87 ? k : k + 1];
        i_bstp_tester.set_pin(1'b0, 1'b0);
        repeat (6) @(posedge mclk);
        chk("extest_on", 143'h0, 143'(extest_on));
        chk("bs_update", 143'h0, bs_update);
        chk("grp_oe", 143'hf, 143'(grp_oe));
        #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        session(1'b0);
        ir_load(bstp_pkg::IR_SAMPLE);
        dr_shift(142, 143'h0);
        chk("chain early", exp, got);
    endtask
    // bypass delays tdi by one cell and leaves the update latch alone
    task automatic bypass_path;
        logic [142:0] keep;
        keep = bs_update;
        ir_load(bstp_pkg::IR_BYPASS);
        dr_shift(4, 143'hb);
        chk("bypass out", 143'h6, got);
        chk("bs_update kept", keep, bs_update);
    endtask
    // verdict and end of run
    task automatic summarize;
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog bounds the run
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        summarize;
    end
    // main sequence
    initial begin
        for (int i = 0; i < 143; i++) pin_state[i] = (i * 7) % 5 < 2;
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        trst_low;
        ir_extest;
        chain_later;
        chain_early;
        bypass_path;
        summarize;
    end
endmodule
`default_nettype wire
